// ### verilog/ovfr_pkg.sv
// Package: register map, field layout, modes and timing constants for the OV response block
package ovfr_pkg;
  localparam logic [7:0] OV_FAULT_THRESHOLD_ADDR = 8'h40;
  localparam logic [7:0] OV_FAULT_RESPONSE_CFG_ADDR = 8'h41;
  localparam logic [7:0] DELAY_UNIT_ADDR = 8'hD2;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [15:0] THRESHOLD_RESET = 16'hFFFF;
  localparam logic [15:0] DELAY_UNIT_RESET = 16'h000A;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // One tick of the delay-unit prescaler, in microseconds, and its cycle count at 10 MHz
  localparam int TICK_US = 1;
  localparam int CLK_MHZ = 10;
  localparam int TICK_CYCLES = (TICK_US * CLK_MHZ < 1) ? 1 : TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_IGNORE = 2'b00,
    MODE_DELAY_RETRY = 2'b01,
    MODE_DISABLE_RETRY = 2'b10,
    MODE_RESUME_OK = 2'b11
  } ovfr_mode_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_GRACE = 3'b001,
    ST_OFF_WAIT = 3'b010,
    ST_RESTART = 3'b011,
    ST_LATCHED = 3'b100,
    ST_HOLD_OFF = 3'b101
  } ovfr_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] retry;
    logic [2:0] delay;
  } ovfr_cfg_s;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ovfr_wr_s;
endpackage : ovfr_pkg

// ### verilog/ovfr_ctrl.sv
// Over-voltage fault response controller: registers, comparator, grace and retry sequencer
`timescale 1ns/10ps
// Behaviour
// R1 - Mode 00 ignores fault, output stays on
// R2 - Mode 01 runs for delay, then retry setting
// R3 - Mode 10 disables at once, then retry setting
// R4 - Mode 11 off while fault, resume after
// R5 - Retry 000 stays off until cleared
// R6 - Retry 1..6 attempts, then latch off
// R7 - Retry 111 retries until commanded off
// R8 - Restart spacing equals delay count times unit
// R9 - Delay field n means 2^n units
// R10 - Unit from separate register; shared delay
// R11 - Host writes whole config byte at 0x41
// R12 - Fault when output above 16-bit threshold
// R13 - Clear or off/on resets counter and timer
module ovfr_ctrl #(
  parameter int UNIT_W = 16,
  parameter int TICK_CYCLES = ovfr_pkg::TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] i_vout,
  input wire logic i_on_cmd,
  input wire logic i_fault_clear,
  input wire logic i_other_fault,
  output logic [7:0] o_cfg_rdata,
  output logic o_ov_fault,
  output logic o_output_en,
  output logic o_latched_off,
  output logic [2:0] o_attempts,
  output logic [2:0] o_state
);
  initial begin
    if (UNIT_W < 8 || UNIT_W > 24 || TICK_CYCLES < 1) begin
      $error("ovfr_ctrl: unsupported parameter values");
    end
  end

  ovfr_pkg::ovfr_cfg_s cfg_q;
  logic [15:0] threshold_q;
  logic [UNIT_W-1:0] unit_q;
  ovfr_pkg::ovfr_state_e state_q, state_d;
  logic [2:0] attempts_q, attempts_d;
  logic [UNIT_W+7:0] timer_q, timer_d;
  logic [UNIT_W+7:0] delay_len;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic fault;
  logic on_q;
  logic restart_req;
  logic out_en_d;
  logic [2:0] retry_lim;

  // Configuration writes; the byte is taken whole
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= ovfr_pkg::CFG_RESET;
      threshold_q <= ovfr_pkg::THRESHOLD_RESET;
      unit_q <= UNIT_W'(ovfr_pkg::DELAY_UNIT_RESET);
    end else if (i_ce && i_reg_we) begin
      case (i_reg_addr)
        ovfr_pkg::OV_FAULT_RESPONSE_CFG_ADDR: cfg_q <= i_reg_wdata[7:0]; // R11
        ovfr_pkg::OV_FAULT_THRESHOLD_ADDR: threshold_q <= i_reg_wdata; // R12
        ovfr_pkg::DELAY_UNIT_ADDR: unit_q <= i_reg_wdata[UNIT_W-1:0]; // R10
        default: ;
      endcase
    end
  end

  assign fault = (i_vout > threshold_q); // R12

  // Prescaler for delay-unit ticks
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= 16'h0000;
    end else if (i_ce) begin
      if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= 16'h0000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
    end
  end
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

  // Delay length in ticks: unit << n gives 2^n units; a zero unit still waits one tick
  assign delay_len = ({8'h00, unit_q} << cfg_q.delay) | (UNIT_W + 8)'(unit_q == '0); // R9 R10

  assign retry_lim = cfg_q.retry;

  // On/off edge tracker for restarting the sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_q <= 1'b0;
    end else if (i_ce) begin
      on_q <= i_on_cmd;
    end
  end
  assign restart_req = i_on_cmd && !on_q;

  always_comb begin
    state_d = state_q;
    attempts_d = attempts_q;
    timer_d = timer_q;
    if (tick && timer_q != '0) begin
      timer_d = timer_q - (UNIT_W + 8)'(1);
    end
    case (state_q)
      ovfr_pkg::ST_RUN: begin
        if (fault) begin
          case (ovfr_pkg::ovfr_mode_e'(cfg_q[ovfr_pkg::MODE_MSB:ovfr_pkg::MODE_LSB]))
            ovfr_pkg::MODE_IGNORE: state_d = ovfr_pkg::ST_RUN; // R1
            ovfr_pkg::MODE_DELAY_RETRY: begin
              state_d = ovfr_pkg::ST_GRACE; // R2
              timer_d = delay_len;
            end
            ovfr_pkg::MODE_DISABLE_RETRY: begin
              state_d = ovfr_pkg::ST_OFF_WAIT; // R3
              timer_d = delay_len;
            end
            ovfr_pkg::MODE_RESUME_OK: state_d = ovfr_pkg::ST_HOLD_OFF; // R4
            default: state_d = ovfr_pkg::ST_RUN;
          endcase
        end
      end
      ovfr_pkg::ST_GRACE: begin
        if (!fault) begin
          state_d = ovfr_pkg::ST_RUN;
        end else if (timer_q == '0) begin
          state_d = ovfr_pkg::ST_OFF_WAIT; // R2
          timer_d = delay_len;
        end
      end
      ovfr_pkg::ST_OFF_WAIT: begin
        if (retry_lim == ovfr_pkg::RETRY_NONE) begin
          state_d = ovfr_pkg::ST_LATCHED; // R5
        end else if (retry_lim != ovfr_pkg::RETRY_FOREVER && attempts_q >= retry_lim) begin
          state_d = ovfr_pkg::ST_LATCHED; // R6
        end else if (timer_q == '0) begin
          state_d = ovfr_pkg::ST_RESTART; // R8
          timer_d = delay_len;
          if (retry_lim != ovfr_pkg::RETRY_FOREVER) begin
            attempts_d = attempts_q + 3'h1; // R6
          end
        end
      end
      ovfr_pkg::ST_RESTART: begin
        if (fault) begin
          state_d = ovfr_pkg::ST_OFF_WAIT; // R8
        end else if (timer_q == '0) begin
          state_d = ovfr_pkg::ST_RUN;
          attempts_d = 3'h0;
        end
      end
      ovfr_pkg::ST_HOLD_OFF: begin
        if (!fault) begin
          state_d = ovfr_pkg::ST_RUN; // R4
        end
      end
      ovfr_pkg::ST_LATCHED: state_d = ovfr_pkg::ST_LATCHED; // R5 R6
      default: state_d = ovfr_pkg::ST_RUN;
    endcase
    // Clear, off command, off/on cycle or another fault end the sequence
    if (i_fault_clear || restart_req) begin
      state_d = ovfr_pkg::ST_RUN; // R13
      attempts_d = 3'h0;
      timer_d = '0;
    end
    if (!i_on_cmd || i_other_fault) begin
      state_d = ovfr_pkg::ST_LATCHED; // R7
      attempts_d = 3'h0;
      timer_d = '0;
    end
  end

  // Sequencer state; starts latched so the output waits for an on command
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ovfr_pkg::ST_LATCHED;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // Restart attempts used so far
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      attempts_q <= 3'h0;
    end else if (i_ce) begin
      attempts_q <= attempts_d; // R6
    end
  end

  // Grace and restart spacing timer, counted in delay-unit ticks
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_q <= '0;
    end else if (i_ce) begin
      timer_q <= timer_d; // R8
    end
  end

  // Output enabled while running, in grace, or during a restart attempt
  assign out_en_d = (state_d == ovfr_pkg::ST_RUN) || (state_d == ovfr_pkg::ST_GRACE)
                    || (state_d == ovfr_pkg::ST_RESTART);

  // Configuration readback lags the register by one cycle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_ce) begin
      o_cfg_rdata <= cfg_q; // R11
    end
  end

  // Comparator result, shown even when the mode ignores it
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ov_fault <= 1'b0;
    end else if (i_ce) begin
      o_ov_fault <= fault; // R12
    end
  end

  // Power stage enable follows the next state, so shutdown is immediate
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_output_en <= 1'b0;
    end else if (i_ce) begin
      o_output_en <= out_en_d; // R1 R3 R4
    end
  end

  // Latched off only matters while the output is commanded on
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_latched_off <= 1'b0;
    end else if (i_ce) begin
      o_latched_off <= (state_d == ovfr_pkg::ST_LATCHED) && i_on_cmd; // R5 R6
    end
  end

  // Attempts used, for status reporting
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_attempts <= 3'h0;
    end else if (i_ce) begin
      o_attempts <= attempts_d;
    end
  end

  // Sequencer state, for status reporting
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_state <= 3'h0;
    end else if (i_ce) begin
      o_state <= state_d;
    end
  end
endmodule : ovfr_ctrl

// ### bench/ovfr_host.sv
// Host model: writes the controller's configuration registers
`timescale 1ns/10ps
module ovfr_host (
  input wire logic i_core_clk,
  output logic o_we,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_we = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  // Whole byte or word in one strobe; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    #1;
    o_we = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_core_clk);
    #1;
    o_we = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
endmodule : ovfr_host

// ### bench/ovfr_ctrl_checker.sv
// Checker: port-level properties of the fault response controller
`timescale 1ns/10ps
module ovfr_ctrl_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_on_cmd,
  input wire logic i_fault_clear,
  input wire logic i_other_fault,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_ov_fault,
  input wire logic o_output_en,
  input wire logic [2:0] o_attempts,
  input wire logic [2:0] o_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic live_q;
  wire logic [7:0] wlo = i_reg_wdata[7:0];
  wire logic quiet = live_q && i_ce && i_on_cmd && !i_other_fault && !i_fault_clear && !i_reg_we;
  // Outputs hold reset zeros until the first enabled edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) live_q <= 1'b0;
    else if (i_ce) live_q <= 1'b1;
  end
  a_cfg_readback: assert property ((i_ce && i_reg_we && i_reg_addr == 8'h41) ##1 i_ce
    |=> o_cfg_rdata == $past(wlo, 2)) else $error("cfg readback wrong");
  a_state_enable: assert property (live_q |-> o_output_en == (o_state inside {3'h0, 3'h1, 3'h3}))
    else $error("enable disagrees with state");
  a_attempt_cap: assert property ($rose(o_state == 3'h3) && !$past(i_reg_we)
    |-> o_attempts <= o_cfg_rdata[5:3] || o_cfg_rdata[5:3] == 3'h7) else $error("too many tries");
  a_ignore_run: assert property (quiet && o_state == 3'h0 && o_cfg_rdata[7:6] == 2'h0
    && !$past(i_reg_we) |=> o_output_en) else $error("ignore mode dropped output");
  a_disable_now: assert property (quiet && o_state == 3'h0 && o_cfg_rdata[7:6] == 2'h2
    && !$past(i_reg_we) ##1 o_ov_fault |-> !o_output_en) else $error("late shutdown");
  a_holdoff_fault: assert property (o_state == 3'h5 |-> o_ov_fault)
    else $error("hold-off without fault");
  a_off_forces: assert property (live_q && i_ce && !i_on_cmd && !i_fault_clear
    |=> o_state == 3'h4) else $error("off command ignored");
  a_other_stops: assert property (live_q && i_ce && i_other_fault && !i_fault_clear
    |=> o_state == 3'h4 && !o_output_en) else $error("other fault ignored");
endmodule : ovfr_ctrl_checker
bind ovfr_ctrl ovfr_ctrl_checker u_chk (.*);

// ### bench/tb_ov_fault_response_ctrl.sv
// Testbench: register table, then fault response scenarios
`timescale 1ns/10ps
module tb_ov_fault_response_ctrl;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic [7:0] e;
  } ovfr_row_s;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic i_on_cmd = 1'b0;
  logic i_fault_clear = 1'b0;
  logic i_other_fault = 1'b0;
  logic [15:0] i_vout = 16'h0000;
  logic i_reg_we, o_ov_fault, o_output_en, o_latched_off;
  logic [7:0] i_reg_addr, o_cfg_rdata;
  logic [15:0] i_reg_wdata;
  logic [2:0] o_attempts, o_state;
  int mismatches = 0;
  int cmp_count = 0;
  ovfr_row_s rows [4] = '{'{8'h41, 16'hAB00, 8'h00}, '{8'h41, 16'h00FF, 8'hFF},
    '{8'h42, 16'h0011, 8'hFF}, '{8'h41, 16'h125A, 8'h5A}};
  always #50 i_core_clk = ~i_core_clk;
  ovfr_host host (.i_core_clk(i_core_clk), .o_we(i_reg_we), .o_addr(i_reg_addr),
    .o_wdata(i_reg_wdata));
  ovfr_ctrl #(.TICK_CYCLES(1)) uut (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Back to run with a new setting, then raise the output above threshold
  task automatic fault(input logic [7:0] cfg);
    $display("Test done at %0t", $time);
    i_vout = 16'h0000;
    host.wr(8'h41, {8'h00, cfg});
    i_fault_clear = 1'b1;
    tick(1);
    i_fault_clear = 1'b0;
    tick(2);
    i_vout = 16'h2000;
    tick(1);
  endtask : fault
  initial begin
    tick(8);
    i_rst_b = 1'b1;
    tick(2);
    chk(o_cfg_rdata, 8'h80);
    chk(8'(o_state), 8'h04);
    i_on_cmd = 1'b1;
    host.wr(8'hD2, 16'h0001);
    host.wr(8'h40, 16'h1000);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      tick(1);
      chk(o_cfg_rdata, rows[i].e);
    end
    fault(8'h00);
    tick(5);
    chk(8'(o_output_en), 8'h01);
    fault(8'h80);
    chk(8'(o_output_en), 8'h00);
    tick(20);
    chk(8'(o_attempts), 8'h00);
    chk(8'(o_latched_off), 8'h01);
    fault(8'h88);
    tick(20);
    chk(8'(o_state), 8'h04);
    chk(8'(o_attempts), 8'h01);
    fault(8'hB8);
    tick(40);
    chk(8'(o_state == 3'h4), 8'h00);
    i_other_fault = 1'b1;
    tick(2);
    chk(8'(o_state), 8'h04);
    i_other_fault = 1'b0;
    fault(8'h4B);
    tick(5);
    chk(8'(o_output_en), 8'h01);
    tick(6);
    chk(8'(o_output_en), 8'h00);
    tick(40);
    chk(8'(o_state), 8'h04);
    fault(8'hC0);
    chk(8'(o_output_en), 8'h00);
    i_vout = 16'h0000;
    tick(2);
    chk(8'(o_output_en), 8'h01);
    i_ce = 1'b0;
    i_vout = 16'h2000;
    tick(3);
    chk(8'(o_output_en), 8'h01);
    chk(8'(o_ov_fault), 8'h00);
    i_ce = 1'b1;
    tick(2);
    chk(8'(o_output_en), 8'h00);
    chk(8'(o_ov_fault), 8'h01);
    give_verdict();
  end
  initial begin
    #(3000 * 100);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_ov_fault_response_ctrl
